/* File: common/dslc_pkg.sv */
// Constants, types and lookup helpers of the dial start line controller.
// Summary of operation
// R1 - Exchange minimum tone field needs both detect selectors
// R2 - Exchange detect: dial after continuous tone duration
// R3 - Other exchange codes: fixed wait, no detection
// R4 - Transfer key then first tone detection when enabled
// R5 - Earth menu offered when transfer selector one zero
// R6 - Transfer selectors two, three pick recording tone pair
// R7 - Earth grounds line 200/300/500/700 ms
// R8 - Flash breaks line 80/110/250/500 ms
// R9 - All first tone selectors one: dial on tone; with tone_unsupported set, fixed 3.5 s wait
// R10 - Other first tone codes: fixed wait, no tone
// R11 - Remote ID second digit within 2 or 1 s
// R12 - Sending busy release per selectors five and six
// R13 - Receiving busy release chosen by selector seven
// R14 - Exchange minimum codes map 0 ms and 210 ms to 2.5 s
// R15 - Exchange detect codes map 3.5/5/7 s or detect
// R16 - First tone wait is 3.5 s times code plus one
// R17 - One-cycle dial start pulse on wait or tone
package dslc_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS     = 1000000;
	localparam int MS_CYCLES     = NS_PER_MS / CLK_PERIOD_NS;
	localparam int MS_W          = 15;

	typedef logic [MS_W-1:0] dslc_ms_t;

	localparam dslc_ms_t EXCH_MIN_MS [8] = '{15'd0, 15'd210, 15'd500,
		15'd800, 15'd900, 15'd1500, 15'd2000, 15'd2500};
	localparam dslc_ms_t EXCH_WAIT_MS [3] = '{15'd3500, 15'd5000, 15'd7000};
	localparam dslc_ms_t EARTH_MS [4] = '{15'd200, 15'd300, 15'd500, 15'd700};
	localparam dslc_ms_t FLASH_MS [4] = '{15'd80, 15'd110, 15'd250, 15'd500};
	localparam int       WAIT_UNIT_MS   = 3500;
	localparam dslc_ms_t RID_LONG_MS    = 15'd2000;
	localparam dslc_ms_t RID_SHORT_MS   = 15'd1000;

	// ------------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_EXCH   = 8'h00;
	localparam logic [7:0] ADDR_XFER   = 8'h04;
	localparam logic [7:0] ADDR_FIRST  = 8'h08;
	localparam logic [7:0] ADDR_CTRL   = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_MASK   = 8'h14;
	localparam logic [7:0] ADDR_STATE  = 8'h18;
	localparam logic [7:0] SW_RESET    = 8'h00;
	localparam logic [6:0] CTRL_RESET  = 7'h00;
	localparam int         NUM_EVENTS  = 5;
	localparam logic [NUM_EVENTS-1:0] MASK_RESET = 5'h00;

	// Status and mask bit positions.
	localparam int EV_DIAL    = 0;
	localparam int EV_RELEASE = 1;
	localparam int EV_RID_OK  = 2;
	localparam int EV_RID_TO  = 3;
	localparam int EV_XFER    = 4;

	// Switch field positions (selector n is bit n-1).
	localparam int EX_MIN_HI  = 1;
	localparam int EX_DET_HI  = 5;
	localparam int EX_RKEY    = 7;
	localparam int XF_NOEARTH = 0;
	localparam int XF_PAIR_LO = 1;
	localparam int XF_EARTH   = 4;
	localparam int XF_FLASH   = 6;
	localparam int FT_CODE    = 0;
	localparam int FT_RID     = 3;
	localparam int FT_BUSY5   = 4;
	localparam int FT_BUSY6   = 5;
	localparam int FT_RXBUSY  = 6;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic connected;
		logic dial_tone;
		logic busy_tone;
	} dslc_line_t;

	typedef struct packed {
		logic tone_unsupported;
		logic use_earth;
		logic remote_rx;
		logic auto_recv;
		logic auto_send;
		logic auto_call;
		logic exchange_mode;
	} dslc_ctrl_t;

	typedef enum logic [2:0] {
		S_IDLE, S_WAIT, S_DET_EXCH, S_DET_PUB, S_XFER, S_HOLD
	} dslc_state_t;

	// ------------------------------------------------------------------
	// Lookups
	// ------------------------------------------------------------------
	function automatic dslc_ms_t dslc_first_wait(input logic [2:0] code);
		dslc_first_wait = MS_W'(WAIT_UNIT_MS * (int'(code) + 1)); // [R16]
	endfunction

	function automatic logic [2:0] dslc_rev3(input logic [2:0] v);
		dslc_rev3 = {v[0], v[1], v[2]};
	endfunction

endpackage

/* File: rtl/dslc_timer.sv */
// Millisecond down-counter with a one-cycle expiry pulse.
`timescale 1ns/100ps
module dslc_timer #(
	parameter int TICK_CYCLES = dslc_pkg::MS_CYCLES
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             load,
	input  wire logic             stop,
	input  wire dslc_pkg::dslc_ms_t load_ms,
	output logic                  expired,
	output logic                  running
);
	import dslc_pkg::*;

	localparam int PW = $clog2(TICK_CYCLES + 1) + 1;

	if (TICK_CYCLES < 1) begin : g_chk
		$error("dslc_timer needs TICK_CYCLES of at least one");
	end

	logic [PW-1:0] pre_q;
	dslc_ms_t      cnt_q;
	wire           tick = (pre_q == PW'(TICK_CYCLES - 1));

	// A load of zero expires after the first tick, like a load of one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q   <= '0;
			cnt_q   <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else if (load) begin
			pre_q   <= '0;
			cnt_q   <= load_ms;
			running <= 1'b1;
			expired <= 1'b0;
		end else if (stop || !running) begin
			running <= 1'b0;
			expired <= 1'b0;
		end else if (tick) begin
			pre_q   <= '0;
			cnt_q   <= cnt_q - 1'b1;
			running <= (cnt_q > 15'h0001);
			expired <= (cnt_q <= 15'h0001);
		end else begin
			pre_q   <= pre_q + 1'b1;
			expired <= 1'b0;
		end
	end

endmodule

/* File: rtl/dslc_top.sv */
// Dial start line controller: call-setup sequencer with an APB slave.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
module dslc_top #(
	parameter int MS_TICK_CYCLES = dslc_pkg::MS_CYCLES,
	parameter int ADDR_W         = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire dslc_pkg::dslc_line_t line_in,
	input  wire logic              transfer_key,
	input  wire logic              remote_digit,
	output logic                   dial_start,
	output logic                   line_release,
	output logic                   earth_on,
	output logic                   flash_break,
	output logic                   earth_menu_en,
	output logic      [1:0]        tone_pair_sel,
	output logic                   remote_id_ok,
	output logic                   irq
);
	import dslc_pkg::*;

	if (ADDR_W < 8) begin : g_chk
		$error("dslc_top needs ADDR_W of at least eight");
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0]            exch_q, xfer_q, first_q;
	dslc_ctrl_t            ctrl_q;
	logic [NUM_EVENTS-1:0] status_q, mask_q;
	dslc_state_t           st_q;
	logic                  dialed_q, released_q, rid_armed_q;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	wire [7:0] a8     = paddr[7:0];
	wire       a_high = (ADDR_W > 8) ? |(paddr >> 8) : 1'b0;
	wire       hit_ex = !a_high && (a8 == ADDR_EXCH);
	wire       hit_xf = !a_high && (a8 == ADDR_XFER);
	wire       hit_ft = !a_high && (a8 == ADDR_FIRST);
	wire       hit_ct = !a_high && (a8 == ADDR_CTRL);
	wire       hit_st = !a_high && (a8 == ADDR_STATUS);
	wire       hit_mk = !a_high && (a8 == ADDR_MASK);
	wire       hit_sa = !a_high && (a8 == ADDR_STATE);
	wire       mapped = hit_ex | hit_xf | hit_ft | hit_ct | hit_st | hit_mk
		| hit_sa;
	wire       wr_en  = psel && penable && pwrite && pready && mapped;
	wire [31:0] rd_data =
		hit_ex ? {24'h000000, exch_q} :
		hit_xf ? {24'h000000, xfer_q} :
		hit_ft ? {24'h000000, first_q} :
		hit_ct ? {25'h0, ctrl_q} :
		hit_st ? {27'h0, status_q} :
		hit_mk ? {27'h0, mask_q} :
		hit_sa ? {24'h000000, released_q, dialed_q, flash_break, earth_on,
			rid_armed_q, st_q} : 32'h00000000;

	// ------------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------------
	wire [2:0] ex_min_code = dslc_rev3(exch_q[EX_MIN_HI+2:EX_MIN_HI]);
	wire [1:0] ex_det_code = {exch_q[EX_DET_HI], exch_q[EX_DET_HI+1]};
	wire       ex_detect   = (ex_det_code == 2'b11); // [R15]
	// The minimum duration is only looked up on the detect path. [R1]
	wire dslc_ms_t ex_min_ms  = EXCH_MIN_MS[ex_min_code]; // [R14]
	wire dslc_ms_t ex_wait_ms = EXCH_WAIT_MS[ex_det_code[1:0] == 2'b11 ?
		2'd0 : ex_det_code]; // [R15]
	wire [2:0] ft_code = dslc_rev3(first_q[FT_CODE+2:FT_CODE]);
	wire       pub_detect = (ft_code == 3'b111)
		&& !ctrl_q.tone_unsupported; // [R9]
	wire dslc_ms_t pub_wait_ms = (ft_code == 3'b111) ?
		dslc_first_wait(3'b000) : dslc_first_wait(ft_code); // [R10]
	wire       earth_ok  = !xfer_q[XF_NOEARTH]; // [R5]
	wire       use_earth = ctrl_q.use_earth && earth_ok;
	wire [1:0] earth_code = {xfer_q[XF_EARTH], xfer_q[XF_EARTH+1]};
	wire [1:0] flash_code = {xfer_q[XF_FLASH], xfer_q[XF_FLASH+1]};
	wire dslc_ms_t xfer_ms = use_earth ? EARTH_MS[earth_code] // [R7]
		: FLASH_MS[flash_code]; // [R8]
	wire [1:0] pair_code = {xfer_q[XF_PAIR_LO], xfer_q[XF_PAIR_LO+1]};
	wire [1:0] pair_d = pair_code[1] ? 2'd2 : {1'b0, pair_code[0]}; // [R6]
	wire       rkey_first = ctrl_q.exchange_mode && ctrl_q.auto_call
		&& !exch_q[EX_RKEY]; // [R4]

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	dslc_state_t st_d;
	logic        tmr_load, dial_ev, xfer_ev;
	dslc_ms_t    tmr_ms;
	logic        tmr_exp, rid_exp;

	always_comb begin
		st_d     = st_q;
		tmr_load = 1'b0;
		tmr_ms   = '0;
		dial_ev  = 1'b0;
		xfer_ev  = 1'b0;
		if (!line_in.connected) begin
			st_d = S_IDLE;
		end else begin
			case (st_q)
			S_IDLE: begin
				tmr_load = 1'b1;
				if (ctrl_q.exchange_mode && ex_detect) begin
					st_d   = S_DET_EXCH; // [R2]
					tmr_ms = ex_min_ms;
				end else if (ctrl_q.exchange_mode) begin
					st_d   = S_WAIT; // [R3]
					tmr_ms = ex_wait_ms;
				end else if (pub_detect) begin
					st_d     = S_DET_PUB; // [R9]
					tmr_load = 1'b0;
				end else begin
					st_d   = S_WAIT; // [R10]
					tmr_ms = pub_wait_ms;
				end
			end
			S_WAIT: begin
				if (tmr_exp) begin
					st_d    = S_HOLD;
					dial_ev = 1'b1; // [R17]
				end
			end
			S_DET_EXCH: begin
				if (tmr_exp && line_in.dial_tone) begin
					st_d    = S_HOLD;
					dial_ev = 1'b1; // [R2]
				end else if (!line_in.dial_tone) begin
					tmr_load = 1'b1; // [R2]
					tmr_ms   = ex_min_ms;
				end
			end
			S_DET_PUB: begin
				if (line_in.dial_tone) begin
					st_d    = S_HOLD;
					dial_ev = 1'b1; // [R9]
				end
			end
			S_HOLD: begin
				if (transfer_key) begin
					st_d     = S_XFER;
					tmr_load = 1'b1;
					tmr_ms   = xfer_ms;
				end
			end
			S_XFER: begin
				if (tmr_exp) begin
					xfer_ev = 1'b1;
					st_d    = S_HOLD;
					if (rkey_first && pub_detect) begin
						st_d = S_DET_PUB; // [R4]
					end else if (rkey_first) begin
						st_d     = S_WAIT; // [R4]
						tmr_load = 1'b1;
						tmr_ms   = pub_wait_ms;
					end
				end
			end
			default: st_d = S_IDLE;
			endcase
		end
	end

	dslc_timer #(.TICK_CYCLES(MS_TICK_CYCLES)) u_seq_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (tmr_load),
		.stop    (!line_in.connected),
		.load_ms (tmr_ms),
		.expired (tmr_exp),
		.running ()
	);

	// ------------------------------------------------------------------
	// Remote ID window and busy release
	// ------------------------------------------------------------------
	wire rid_dig    = ctrl_q.remote_rx && line_in.connected && remote_digit;
	wire rid_first  = rid_dig && !rid_armed_q;
	wire rid_second = rid_dig && rid_armed_q; // [R11]
	wire rid_to     = rid_armed_q && rid_exp && !rid_second;
	wire dslc_ms_t rid_ms = first_q[FT_RID] ? RID_SHORT_MS
		: RID_LONG_MS; // [R11]

	dslc_timer #(.TICK_CYCLES(MS_TICK_CYCLES)) u_rid_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (rid_first),
		.stop    (rid_second || !ctrl_q.remote_rx),
		.load_ms (rid_ms),
		.expired (rid_exp),
		.running ()
	);

	wire send_ok = ctrl_q.auto_send && first_q[FT_BUSY6]
		&& (first_q[FT_BUSY5] || dialed_q); // [R12]
	wire recv_ok = ctrl_q.auto_recv && !first_q[FT_RXBUSY]; // [R13]
	wire rel_ev  = line_in.connected && line_in.busy_tone && !released_q
		&& (send_ok || recv_ok);

	// ------------------------------------------------------------------
	// Status, flags and outputs
	// ------------------------------------------------------------------
	wire [NUM_EVENTS-1:0] ev = {xfer_ev, rid_to, rid_second, rel_ev,
		dial_ev};
	wire [NUM_EVENTS-1:0] w1c = (wr_en && hit_st) ?
		pwdata[NUM_EVENTS-1:0] : '0;
	// A new event outweighs a clear written in the same cycle.
	wire [NUM_EVENTS-1:0] status_d = (status_q & ~w1c) | ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exch_q  <= SW_RESET;
			xfer_q  <= SW_RESET;
			first_q <= SW_RESET;
			ctrl_q  <= CTRL_RESET;
			mask_q  <= MASK_RESET;
		end else if (wr_en) begin
			if (hit_ex) exch_q <= pwdata[7:0];
			if (hit_xf) xfer_q <= pwdata[7:0];
			if (hit_ft) first_q <= pwdata[7:0];
			if (hit_ct) ctrl_q <= pwdata[6:0];
			if (hit_mk) mask_q <= pwdata[NUM_EVENTS-1:0];
		end
	end

	// The slave always answers with one wait-free access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? rd_data : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q          <= S_IDLE;
			status_q      <= '0;
			irq           <= 1'b0;
			dial_start    <= 1'b0;
			line_release  <= 1'b0;
			remote_id_ok  <= 1'b0;
			earth_on      <= 1'b0;
			flash_break   <= 1'b0;
			earth_menu_en <= 1'b0;
			tone_pair_sel <= 2'd0;
			dialed_q      <= 1'b0;
			released_q    <= 1'b0;
			rid_armed_q   <= 1'b0;
		end else begin
			st_q          <= st_d;
			status_q      <= status_d;
			irq           <= |(status_d & mask_q);
			dial_start    <= dial_ev; // [R17]
			line_release  <= rel_ev; // [R12] [R13]
			remote_id_ok  <= rid_second; // [R11]
			earth_on      <= (st_d == S_XFER) && use_earth; // [R7]
			flash_break   <= (st_d == S_XFER) && !use_earth; // [R8]
			earth_menu_en <= earth_ok; // [R5]
			tone_pair_sel <= pair_d; // [R6]
			dialed_q      <= line_in.connected && (dialed_q || dial_ev);
			released_q    <= line_in.connected && (released_q || rel_ev);
			rid_armed_q   <= rid_first || (rid_armed_q && !rid_second
				&& !rid_exp && ctrl_q.remote_rx && line_in.connected);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_dial_one_pulse: assert property ( // [R17]
		dial_start |=> !dial_start) else $error("dial start too long");
	a_exch_gate: assert property ( // [R1]
		$rose(st_q == S_DET_EXCH) |-> $past(ex_detect))
		else $error("exchange detect entered without both selectors");
	a_exch_wait_path: assert property ( // [R3]
		st_q == S_IDLE && line_in.connected && ctrl_q.exchange_mode
		&& !ex_detect |=> st_q == S_WAIT) else $error("no exchange wait");
	a_exch_tone_hold: assert property ( // [R2]
		st_q == S_DET_EXCH && !line_in.dial_tone |=> !dial_start)
		else $error("dial started without tone");
	a_pub_tone_start: assert property ( // [R9]
		st_q == S_DET_PUB && line_in.connected && line_in.dial_tone
		|=> dial_start && st_q == S_HOLD) else $error("no start on tone");
	a_wait_no_start: assert property ( // [R10]
		st_q == S_WAIT && !tmr_exp |=> !dial_start)
		else $error("dial started before wait end");
	a_earth_menu: assert property ( // [R5]
		$past(presetn) |-> earth_menu_en == !$past(xfer_q[XF_NOEARTH]))
		else $error("earth menu wrong");
	a_tone_pair: assert property ( // [R6]
		$past(pair_code) == 2'b01 |-> tone_pair_sel == 2'd1)
		else $error("tone pair wrong");
	a_earth_flash: assert property ( // [R7]
		!(earth_on && flash_break)) else $error("earth and flash together");
	a_busy_ignore: assert property ( // [R12]
		ctrl_q.auto_send && !ctrl_q.auto_recv && !first_q[FT_BUSY6]
		|=> !line_release) else $error("busy not ignored");
	a_recv_release: assert property ( // [R13]
		ctrl_q.auto_recv && !first_q[FT_RXBUSY] && line_in.connected
		&& line_in.busy_tone && !released_q |=> line_release)
		else $error("busy release missing");
	a_rid_armed: assert property ( // [R11]
		remote_id_ok |-> $past(rid_armed_q))
		else $error("remote id accepted unarmed");

endmodule

/* File: test/dslc_line_model.sv */
// Behavioural model of the exchange line seen by the controller.
`timescale 1ns/100ps
module dslc_line_model (
	input  wire logic           pclk,
	output dslc_pkg::dslc_line_t line_in
);
	import dslc_pkg::*;

	initial line_in = '0;

	// ------------------------------------------------------------------
	// Call shape
	// ------------------------------------------------------------------
	// A negative cycle number means that the event never happens.
	// Tones are absent whenever the line is down, as on a real loop.
	task automatic call(input int on, input int off, input int back,
		input int hold, input int busy);
		for (int i = 0; i < hold; i++) begin
			@(posedge pclk);
			line_in.connected <= 1'b1;
			if (i == on || i == back) line_in.dial_tone <= 1'b1;
			if (i == off) line_in.dial_tone <= 1'b0;
			if (i == busy) line_in.busy_tone <= 1'b1;
		end
		@(posedge pclk);
		line_in <= '0;
	endtask
endmodule

/* File: test/test_dslc_top.sv */
// Self-checking bench of the dial start line controller.
`timescale 1ns/100ps
module test_dslc_top;
	import dslc_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic        pready, pslverr, transfer_key = 0, remote_digit = 0;
	logic        dial_start, line_release, earth_on, flash_break;
	logic        earth_menu_en, remote_id_ok, irq;
	logic [1:0]  tone_pair_sel;
	dslc_line_t  line_in;
	int          err_count = 0, checked = 0, cyc = 0, run = 0;
	int          rel_cnt = 0, ok_cnt = 0, n;
	int          seed = 32'h31c735b3;
	logic [31:0] v;
	logic [32:0] rd_q[$];
	int          dial_q[$], len_q[$];
	logic [7:0]  ra[5] = '{ADDR_EXCH, ADDR_XFER, ADDR_FIRST, ADDR_CTRL,
		ADDR_MASK};
	logic [7:0]  bft[5] = '{8'h30, 8'h10, 8'h20, 8'h00, 8'h40};
	logic [6:0]  bct[5] = '{7'h04, 7'h04, 7'h04, 7'h08, 7'h08};
	int          bex[5] = '{1, 0, 0, 1, 0};

	// One cycle per millisecond tick keeps the longest wait short.
	dslc_top #(.MS_TICK_CYCLES(1), .ADDR_W(8)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_in(line_in),
		.transfer_key(transfer_key), .remote_digit(remote_digit),
		.dial_start(dial_start), .line_release(line_release),
		.earth_on(earth_on), .flash_break(flash_break),
		.earth_menu_en(earth_menu_en), .tone_pair_sel(tone_pair_sel),
		.remote_id_ok(remote_id_ok), .irq(irq));
	dslc_line_model lm (.pclk(pclk), .line_in(line_in));

	always #5 pclk = ~pclk;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [32:0] e,
		input logic [32:0] s);
		checked++;
		if (e !== s) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rd_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
	endtask

	task automatic dig();
		remote_digit <= 1'b1;
		@(posedge pclk);
		remote_digit <= 1'b0;
	endtask

	// Expected dial moment is the connect or tone edge plus the wait.
	task automatic dial(input logic [7:0] ex, input logic [7:0] ft,
		input logic [6:0] ctl, input int ms, input int on, input int off,
		input int back);
		int tw;
		tw = back >= 0 ? back : (on >= 0 ? on : 0);
		apb(1'b1, ADDR_EXCH, {24'h0, ex});
		apb(1'b1, ADDR_FIRST, {24'h0, ft});
		apb(1'b1, ADDR_CTRL, {25'h0, ctl});
		dial_q.push_back(cyc + ms + tw + 1);
		lm.call(on, off, back, ms + tw + 40, -1);
		wt(5);
		chk("dial_pending", 0, dial_q.size());
		$display("dial test done");
	endtask

	task automatic xfer(input logic [6:0] ctl, input logic [7:0] xf,
		input int len, input bit redial);
		apb(1'b1, ADDR_EXCH, 32'h68);
		apb(1'b1, ADDR_FIRST, 32'h07);
		apb(1'b1, ADDR_XFER, {24'h0, xf});
		apb(1'b1, ADDR_CTRL, {25'h0, ctl});
		dial_q.push_back(cyc + 6 + (ctl[0] ? 210 : 0));
		len_q.push_back(len);
		fork
			lm.call(5, -1, -1, 1500, -1);
			begin
				wt(300);
				transfer_key <= 1'b1;
				if (redial) dial_q.push_back(cyc + len + 1);
				@(posedge pclk);
				transfer_key <= 1'b0;
			end
		join
		wt(5);
		chk("dial_pending", 0, dial_q.size());
		chk("xfer_pending", 0, len_q.size());
		$display("transfer test done");
	endtask

	// ------------------------------------------------------------------
	// Output monitor and timeout
	// ------------------------------------------------------------------
	always @(posedge pclk) begin
		int e;
		cyc <= cyc + 1;
		if (psel && penable && pready === 1'b1 && !pwrite
			&& rd_q.size() > 0) chk("prdata", rd_q.pop_front(),
			{pslverr, prdata});
		if (dial_start === 1'b1) begin
			if (dial_q.size() == 0) chk("dial_extra", 0, 1);
			else begin
				e = dial_q.pop_front();
				chk("dial_time", 1, cyc >= e && cyc <= e + 8);
			end
		end
		if (line_release === 1'b1) rel_cnt++;
		if (remote_id_ok === 1'b1) ok_cnt++;
		if (earth_on === 1'b1 || flash_break === 1'b1) run++;
		else if (run > 0) begin
			e = len_q.size() > 0 ? len_q.pop_front() : 0;
			chk("xfer_len", 1, run >= e - 1 && run <= e + 2);
			run = 0;
		end
		if (cyc > 80000) begin
			err_count++;
			$display("BAD timeout exp done got hang");
			wrap_up();
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		wt(10);
		presetn <= 1'b1;
		wt(2);
		chk("menu_en", 1, earth_menu_en);
		foreach (ra[i]) rd(ra[i], 33'h0);
		rd(8'h1c, 33'h100000000);
		v = $random(seed);
		apb(1'b1, ADDR_EXCH, v);
		rd(ADDR_EXCH, {25'h0, v[7:0]});
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ADDR_XFER, {29'h0, i[1:0], i[0]});
			wt(3);
			chk("pair", i[0] ? 2 : (i[1] ? 1 : 0), tone_pair_sel);
			chk("menu_en", !i[0], earth_menu_en);
		end
		$display("register test done");
		apb(1'b1, ADDR_MASK, 32'h1);
		dial(8'h00, 8'h00, 7'h00, 3500, -1, -1, -1);
		rd(ADDR_STATUS, 33'h1);
		chk("irq", 1, irq);
		apb(1'b1, ADDR_STATUS, 32'h1);
		apb(1'b1, ADDR_MASK, 32'h0);
		wt(3);
		chk("irq", 0, irq);
		dial(8'h00, 8'h03, 7'h00, 24500, -1, -1, -1);
		chk("irq", 0, irq);
		dial(8'h00, 8'h07, 7'h40, 3500, -1, -1, -1);
		dial(8'h00, 8'h07, 7'h00, 0, 10, -1, -1);
		dial(8'h0e, 8'h07, 7'h01, 3500, -1, -1, -1);
		dial(8'h40, 8'h07, 7'h01, 5000, -1, -1, -1);
		dial(8'h20, 8'h07, 7'h01, 7000, -1, -1, -1);
		dial(8'h6e, 8'h00, 7'h01, 2500, 10, 500, 600);
		xfer(7'h23, 8'h30, 700, 1'b1);
		xfer(7'h20, 8'h01, 80, 1'b0);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, ADDR_CTRL, 32'h10);
			apb(1'b1, ADDR_FIRST, i * 8);
			n = ok_cnt;
			fork
				lm.call(-1, -1, -1, 1700, -1);
				begin
					wt(20);
					dig();
					wt(1500);
					dig();
				end
			join
			wt(5);
			chk("remote_ok", i ? 0 : 1, ok_cnt - n);
		end
		rd(ADDR_STATUS, 33'h1d);
		foreach (bft[i]) begin
			apb(1'b1, ADDR_FIRST, {24'h0, bft[i]});
			apb(1'b1, ADDR_CTRL, {25'h0, bct[i]});
			n = rel_cnt;
			lm.call(-1, -1, -1, 300, 100);
			wt(5);
			chk("release", bex[i], rel_cnt - n);
		end
		apb(1'b1, ADDR_FIRST, 32'h27);
		apb(1'b1, ADDR_CTRL, 32'h04);
		n = rel_cnt;
		dial_q.push_back(cyc + 11);
		lm.call(10, -1, -1, 300, 100);
		wt(5);
		chk("release_dialed", 1, rel_cnt - n);
		$display("busy and remote tests done");
		wrap_up();
	end
endmodule
